// ---- bench/gso_agc_observer_test.sv ----
// Self-checking bench for the gain state observer
module gso_agc_observer_test
    import gso_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int LIMIT = 20000;
    logic clk = 1'b0, rstn = 1'b0, rx_mode = 1'b1, no_high_opt = 1'b0, adc_clip = 1'b0;
    logic fs_detect = 1'b0, burst_end = 1'b0, monitor_en = 1'b0, monitor_sel = SEL_ADC;
    logic [1:0]         agc_mode = MODE_LOCK;
    logic [2:0]         manual_step = 3'h7, min_step = 3'h0, exp_step;
    logic signed [15:0] rx_sample = 16'h0000;
    logic [15:0]        detect_thr = 16'h03E8, high_thr = 16'h4E20, low_thr = 16'h0064;
    logic [7:0]         low_units = 8'hC8, settle_units = 8'h00, fs_timeout_units = 8'hC8;
    logic [9:0]         adc_result_in = 10'h000, dac_level_in = 10'h000, seen_code;
    logic [9:0]         aux_adc_result_r, aux_dac_level_r;
    logic [2:0]         gain_step_r;
    logic               gain_up_r, gain_dn_r, preamble_det_r, fs_det_r, hit;
    logic [31:0]        seed = 32'h000156FD;
    int                 mismatches = 0, n_compared = 0, cycles = 0;

    gso_agc_observer #(.UNIT_CYCLES(4)) i_dut (
        .clk(clk), .rstn(rstn), .rx_mode(rx_mode), .agc_mode(agc_mode), .no_high_opt(no_high_opt),
        .manual_step(manual_step), .min_step(min_step), .rx_sample(rx_sample), .adc_clip(adc_clip),
        .fs_detect(fs_detect), .burst_end(burst_end), .detect_thr(detect_thr), .high_thr(high_thr),
        .low_thr(low_thr), .low_units(low_units), .settle_units(settle_units),
        .fs_timeout_units(fs_timeout_units), .monitor_en(monitor_en), .monitor_sel(monitor_sel),
        .adc_result_in(adc_result_in), .dac_level_in(dac_level_in), .aux_adc_result_r(aux_adc_result_r),
        .aux_dac_level_r(aux_dac_level_r), .gain_step_r(gain_step_r), .gain_up_r(gain_up_r),
        .gain_dn_r(gain_dn_r), .preamble_det_r(preamble_det_r), .fs_det_r(fs_det_r)
    );

    gso_host_model i_host (
        .clk(clk), .rstn(rstn), .monitor_en(monitor_en), .monitor_sel(monitor_sel),
        .aux_adc_result_r(aux_adc_result_r), .aux_dac_level_r(aux_dac_level_r), .seen_code(seen_code)
    );

    always #12.5 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed = seed[0] ? ((seed >> 1) ^ 32'hA3000000) : (seed >> 1);
        return seed;
    endfunction

    // Expected value of a converter path: the code when borrowed, else its own input
    function automatic logic [9:0] exp_path(logic borrowed, logic [9:0] code, logic [9:0] normal);
        return borrowed ? code : normal;
    endfunction

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Bounded wait: 0 preamble up, 1 frame sync up, 2 step down pulse, 4 step up pulse, else back to waiting
    task automatic wait_for(int which, int n, output logic found);
        found = 1'b0;
        for (int i = 0; i < n && !found; i++) begin
            tick(1);
            case (which)
                0: found = (preamble_det_r === 1'b1);
                1: found = (fs_det_r === 1'b1);
                2: found = (gain_dn_r === 1'b1);
                4: found = (gain_up_r === 1'b1);
                default: found = (preamble_det_r === 1'b0);
            endcase
        end
    endtask

    // Random converter values every second cycle, both paths compared with the routing expected
    task automatic pass_chk(int n, logic [9:0] code);
        logic [31:0] r;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            r = rnd();
            adc_result_in <= r[9:0];
            dac_level_in  <= r[25:16];
            tick(1);
            chk("adc path", exp_path(monitor_en && monitor_sel == SEL_ADC, code, r[9:0]), aux_adc_result_r);
            chk("dac path", exp_path(monitor_en && monitor_sel == SEL_DAC, code, r[25:16]), aux_dac_level_r);
        end
    endtask

    task automatic pulse_clip();
        @(posedge clk);
        adc_clip <= 1'b1;
        @(posedge clk);
        adc_clip <= 1'b0;
    endtask

    task automatic burst();
        @(posedge clk);
        rx_sample <= 16'h1388;
        wait_for(0, 4, hit);
        chk("burst start", 16'h0001, {15'h0000, hit});
    endtask

    task automatic frame_sync();
        @(posedge clk);
        fs_detect <= 1'b1;
        @(posedge clk);
        fs_detect <= 1'b0;
        wait_for(1, 6, hit);
        chk("frame sync", 16'h0001, {15'h0000, hit});
    endtask

    task automatic finish_burst();
        @(posedge clk);
        rx_sample <= 16'h0000;
        burst_end <= 1'b1;
        @(posedge clk);
        burst_end <= 1'b0;
        wait_for(3, 6, hit);
        chk("back to waiting", 16'h0001, {15'h0000, hit});
        pass_chk(2, CODE_WAIT);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        tick(1);
        chk("reset step", 16'h0007, gain_step_r);
        chk("reset preamble", 16'h0000, preamble_det_r);
        pass_chk(6, CODE_WAIT);
        @(posedge clk);
        monitor_en <= 1'b1;
        tick(2);
        pass_chk(4, CODE_WAIT);
        chk("host code", CODE_WAIT, seen_code);
        burst();
        pass_chk(2, CODE_BURST);
        @(posedge clk);
        monitor_sel <= SEL_DAC;
        tick(2);
        pass_chk(3, CODE_BURST);
        pulse_clip();
        wait_for(2, 6, hit);
        chk("clip in burst", 16'h0006, {13'h0000, gain_step_r});
        frame_sync();
        pass_chk(2, CODE_FS_LOCK);
        pulse_clip();
        tick(8);
        chk("locked step", 16'h0006, gain_step_r);
        finish_burst();
        @(posedge clk);
        agc_mode <= MODE_DOWN;
        burst();
        frame_sync();
        pass_chk(2, CODE_FS_DOWN);
        chk("host code", CODE_FS_DOWN, seen_code);
        pulse_clip();
        wait_for(2, 6, hit);
        chk("down only step", 16'h0005, gain_step_r);
        finish_burst();
        @(posedge clk);
        agc_mode <= MODE_FULL;
        burst();
        frame_sync();
        pass_chk(2, CODE_BURST);
        chk("any action flag", 16'h0001, fs_det_r);
        finish_burst();
        @(posedge clk);
        agc_mode    <= MODE_LOCK;
        no_high_opt <= 1'b1;
        burst();
        tick(10);
        pass_chk(2, CODE_PRE_NOHI);
        @(posedge clk);
        rx_sample <= 16'h61A8;
        tick(10);
        chk("no high step", 16'h0005, gain_step_r);
        frame_sync();
        pass_chk(2, CODE_FS_LOCK);
        finish_burst();
        // Quiet input while waiting, with a short low period, must raise the gain by one step
        @(posedge clk);
        low_units <= 8'h03;
        wait_for(4, 24, hit);
        chk("low step up", 16'h0001, {15'h0000, hit});
        chk("stepped up", 16'h0006, gain_step_r);
        // Manual step must hold whether or not the modem is receiving
        @(posedge clk);
        no_high_opt <= 1'b0;
        monitor_en  <= 1'b0;
        agc_mode    <= MODE_MANUAL;
        for (int k = 0; k < 8; k++) begin
            exp_step = k[2:0];
            @(posedge clk);
            rx_mode     <= seed[3];
            manual_step <= exp_step;
            void'(rnd());
            tick(3);
            chk("manual step", {13'h0000, exp_step}, {13'h0000, gain_step_r});
        end
        pass_chk(4, CODE_WAIT);
        end_sim();
    end
endmodule

// ---- bench/gso_host_model.sv ----
// Host side model that reads the state code from the converter path chosen for observation
module gso_host_model
    import gso_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              monitor_en,
    input  wire logic              monitor_sel,
    input  wire logic [CODE_W-1:0] aux_adc_result_r,
    input  wire logic [CODE_W-1:0] aux_dac_level_r,
    output logic      [CODE_W-1:0] seen_code
);
    timeunit 1ns;
    timeprecision 100ps;

    // The host only trusts the borrowed path while it has observation switched on
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seen_code <= 10'h000;
        end else if (monitor_en) begin
            seen_code <= (monitor_sel == SEL_DAC) ? aux_dac_level_r : aux_adc_result_r;
        end
    end
endmodule

// ---- hdl/gso_agc_observer.sv ----
// Receive gain control state machine with optional state observation output
// What this block does
// [RULE1] Gain control state stays hidden unless observation is enabled.
// [RULE2] When enabled, the state code replaces the selected ADC result or DAC level.
// [RULE3] The chosen converter path loses its normal value while observation is on.
// [RULE4] Host enables observation and picks DAC or ADC; configuration use only.
// [RULE5] Waiting state, timers reset: code 000, clip, high and low all act.
// [RULE6] Burst start sets preamble indication, code 100, all three cases act.
// [RULE7] Preamble with no-high option: code 200, clip and low act.
// [RULE8] Frame sync with lock option: code 300, no gain action at all.
// [RULE9] Frame sync with down-only option: code 380, clip and high act.
// [RULE10] Frame sync with any-action option: code unchanged, all cases act.
// [RULE11] Signal sensed after short latency; frame sync arrives later from filter.
// [RULE12] Eight gain steps, 0 lowest gain, 7 highest gain.
// [RULE13] Automatic modes act only in receive; manual step applies in any mode.
// [RULE14] First crossing of the detect threshold marks burst start.
// [RULE15] Timers count 6/5 symbol units; thresholds compare 16 bit sample magnitude.
// [RULE16] Disabling observation returns the borrowed converter path to normal.
// [RULE17] Code follows each state change within one timing unit, except any-action state.
module gso_agc_observer
    import gso_pkg::*;
#(
    parameter int UNIT_CYCLES = gso_pkg::UNIT_CYCLES
) (
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic                rx_mode,
    input  wire logic [1:0]          agc_mode,
    input  wire logic                no_high_opt,
    input  wire logic [STEP_W-1:0]   manual_step,
    input  wire logic [STEP_W-1:0]   min_step,
    input  wire logic signed [15:0]  rx_sample,
    input  wire logic                adc_clip,
    input  wire logic                fs_detect,
    input  wire logic                burst_end,
    input  wire logic [MAG_W-1:0]    detect_thr,
    input  wire logic [MAG_W-1:0]    high_thr,
    input  wire logic [MAG_W-1:0]    low_thr,
    input  wire logic [TIME_W-1:0]   low_units,
    input  wire logic [TIME_W-1:0]   settle_units,
    input  wire logic [TIME_W-1:0]   fs_timeout_units,
    input  wire logic                monitor_en,
    input  wire logic                monitor_sel,
    input  wire logic [CODE_W-1:0]   adc_result_in,
    input  wire logic [CODE_W-1:0]   dac_level_in,
    output logic [CODE_W-1:0]        aux_adc_result_r,
    output logic [CODE_W-1:0]        aux_dac_level_r,
    output logic [STEP_W-1:0]        gain_step_r,
    output logic                     gain_up_r,
    output logic                     gain_dn_r,
    output logic                     preamble_det_r,
    output logic                     fs_det_r
);

    function automatic logic [2:0] allow_mask(input gso_state_e st);
        logic [2:0] m;
        m = 3'h7;
        unique case (st)
            ST_WAIT:     m = 3'h7;                                 // [RULE5]
            ST_BURST:    m = 3'h7;                                 // [RULE6]
            ST_PRE_NOHI: m = 3'h7 & ~(3'h1 << ACT_HI);             // [RULE7]
            ST_FS_LOCK:  m = 3'h0;                                 // [RULE8]
            ST_FS_DOWN:  m = 3'h7 & ~(3'h1 << ACT_LO);             // [RULE9]
            ST_FS_ANY:   m = 3'h7;                                 // [RULE10]
            default:     m = 3'h0;
        endcase
        return m;
    endfunction

    function automatic logic [CODE_W-1:0] obs_code(input gso_state_e st, input logic [CODE_W-1:0] prev);
        logic [CODE_W-1:0] c;
        c = prev;
        unique case (st)
            ST_WAIT:     c = CODE_WAIT;
            ST_BURST:    c = CODE_BURST;
            ST_PRE_NOHI: c = CODE_PRE_NOHI;
            ST_FS_LOCK:  c = CODE_FS_LOCK;
            ST_FS_DOWN:  c = CODE_FS_DOWN;
            ST_FS_ANY:   c = prev;
            default:     c = prev;
        endcase
        return c;
    endfunction

    gso_state_e        state_r;
    gso_state_e        state_nxt;
    logic [MAG_W-1:0]  mag_r;
    logic [MAG_W-1:0]  mag_nxt;
    logic              clip_r;
    logic [TIME_W-1:0] settle_cnt_r;
    logic [TIME_W-1:0] settle_cnt_nxt;
    logic [TIME_W-1:0] low_cnt_r;
    logic [TIME_W-1:0] low_cnt_nxt;
    logic [TIME_W-1:0] burst_cnt_r;
    logic [TIME_W-1:0] burst_cnt_nxt;
    logic [STEP_W-1:0] gain_step_nxt;
    logic              gain_up_nxt;
    logic              gain_dn_nxt;
    logic [CODE_W-1:0] code_r;
    logic [CODE_W-1:0] code_nxt;
    logic [CODE_W-1:0] aux_adc_nxt;
    logic [CODE_W-1:0] aux_dac_nxt;
    logic              rx_active;
    logic              unit_tick;
    logic [2:0]        allow;
    logic              want_dn;
    logic              low_now;

    // Timers are held in reset while the automatic function is idle
    gso_unit_tick #(
        .UNIT_CYCLES (UNIT_CYCLES)
    ) u_tick (
        .clk    (clk),
        .rstn   (rstn),
        .clear  (!rx_active),
        .tick_r (unit_tick)
    );

    assign rx_active = rx_mode && (agc_mode != MODE_MANUAL);          // [RULE13]
    assign allow     = allow_mask(state_r);

    // One register stage of sensing; frame sync arrives much later from the filter path
    always_comb begin
        mag_nxt = (rx_sample < 0) ? MAG_W'(-rx_sample) : MAG_W'(rx_sample);   // [RULE15] [RULE11]
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mag_r  <= '0;
            clip_r <= 1'b0;
        end else begin
            mag_r  <= mag_nxt;
            clip_r <= adc_clip;
        end
    end

    // State and timers
    always_comb begin
        state_nxt      = state_r;
        burst_cnt_nxt  = burst_cnt_r;
        if (!rx_active) begin
            state_nxt     = ST_WAIT;                                   // [RULE5]
            burst_cnt_nxt = '0;
        end else begin
            unique case (state_r)
                ST_WAIT: begin
                    burst_cnt_nxt = '0;
                    if (mag_r > detect_thr) begin
                        state_nxt = ST_BURST;                          // [RULE14] [RULE6]
                    end
                end
                ST_BURST, ST_PRE_NOHI: begin
                    if (unit_tick) begin
                        burst_cnt_nxt = burst_cnt_r + TIME_W'(1);      // [RULE15]
                    end
                    if (fs_detect) begin
                        unique case (gso_mode_e'(agc_mode))
                            MODE_LOCK: state_nxt = ST_FS_LOCK;         // [RULE8]
                            MODE_DOWN: state_nxt = ST_FS_DOWN;         // [RULE9]
                            default:   state_nxt = ST_FS_ANY;          // [RULE10]
                        endcase
                    end else if (burst_cnt_r >= fs_timeout_units) begin
                        state_nxt = ST_WAIT;
                    end else if (state_r == ST_BURST && no_high_opt && unit_tick) begin
                        state_nxt = ST_PRE_NOHI;                       // [RULE7]
                    end
                end
                ST_FS_LOCK, ST_FS_DOWN, ST_FS_ANY: begin
                    if (burst_end) begin
                        state_nxt = ST_WAIT;
                    end
                end
                default: state_nxt = ST_WAIT;
            endcase
        end
    end

    // Gain stepping; a settle period after each change keeps one step per response
    always_comb begin
        gain_step_nxt  = gain_step_r;
        gain_up_nxt    = 1'b0;
        gain_dn_nxt    = 1'b0;
        settle_cnt_nxt = settle_cnt_r;
        low_cnt_nxt    = low_cnt_r;
        want_dn        = (allow[ACT_CLIP] && clip_r) || (allow[ACT_HI] && mag_r > high_thr);
        low_now        = allow[ACT_LO] && (mag_r < low_thr) && !clip_r;
        if (agc_mode == MODE_MANUAL) begin
            gain_step_nxt  = manual_step;                              // [RULE13] [RULE12]
            settle_cnt_nxt = '0;
            low_cnt_nxt    = '0;
        end else if (!rx_active) begin
            settle_cnt_nxt = '0;
            low_cnt_nxt    = '0;
        end else begin
            if (settle_cnt_r != '0 && unit_tick) begin
                settle_cnt_nxt = settle_cnt_r - TIME_W'(1);
            end
            if (!low_now) begin
                low_cnt_nxt = '0;
            end else if (unit_tick && low_cnt_r < low_units) begin
                low_cnt_nxt = low_cnt_r + TIME_W'(1);
            end
            if (settle_cnt_r == '0) begin
                if (want_dn && gain_step_r > min_step) begin
                    gain_step_nxt  = gain_step_r - STEP_ONE;           // [RULE12]
                    gain_dn_nxt    = 1'b1;
                    settle_cnt_nxt = settle_units;
                    low_cnt_nxt    = '0;
                end else if (!want_dn && low_now && low_cnt_r >= low_units && gain_step_r < STEP_TOP) begin
                    gain_step_nxt  = gain_step_r + STEP_ONE;           // [RULE12]
                    gain_up_nxt    = 1'b1;
                    settle_cnt_nxt = settle_units;
                    low_cnt_nxt    = '0;
                end
            end
        end
    end

    // Observation routing; code is computed always but only exposed when enabled
    always_comb begin
        code_nxt    = obs_code(state_nxt, code_r);                      // [RULE17] [RULE10]
        aux_adc_nxt = adc_result_in;                                    // [RULE1] [RULE16]
        aux_dac_nxt = dac_level_in;
        if (monitor_en && monitor_sel == SEL_ADC) begin
            aux_adc_nxt = code_nxt;                                     // [RULE2] [RULE3]
        end
        if (monitor_en && monitor_sel == SEL_DAC) begin
            aux_dac_nxt = code_nxt;                                     // [RULE2] [RULE3]
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r          <= ST_WAIT;
            burst_cnt_r      <= '0;
            settle_cnt_r     <= '0;
            low_cnt_r        <= '0;
            gain_step_r      <= STEP_TOP;
            gain_up_r        <= 1'b0;
            gain_dn_r        <= 1'b0;
            code_r           <= CODE_WAIT;
            aux_adc_result_r <= '0;
            aux_dac_level_r  <= '0;
            preamble_det_r   <= 1'b0;
            fs_det_r         <= 1'b0;
        end else begin
            state_r          <= state_nxt;
            burst_cnt_r      <= burst_cnt_nxt;
            settle_cnt_r     <= settle_cnt_nxt;
            low_cnt_r        <= low_cnt_nxt;
            gain_step_r      <= gain_step_nxt;
            gain_up_r        <= gain_up_nxt;
            gain_dn_r        <= gain_dn_nxt;
            code_r           <= code_nxt;
            aux_adc_result_r <= aux_adc_nxt;
            aux_dac_level_r  <= aux_dac_nxt;
            preamble_det_r   <= (state_nxt != ST_WAIT);                 // [RULE6]
            fs_det_r         <= (state_nxt == ST_FS_LOCK) || (state_nxt == ST_FS_DOWN) ||
                                (state_nxt == ST_FS_ANY);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_HIDDEN: assert property (!monitor_en |=> aux_adc_result_r == $past(adc_result_in) && // [RULE1]
                                 aux_dac_level_r == $past(dac_level_in))
        else $error("converter path altered while observation is off");
    AST_ADC_CARRIES_CODE: assert property (monitor_en && monitor_sel == SEL_ADC |=> // [RULE2]
                                           aux_adc_result_r == code_r && aux_dac_level_r == $past(dac_level_in))
        else $error("ADC result does not carry the state code");
    AST_DAC_CARRIES_CODE: assert property (monitor_en && monitor_sel == SEL_DAC |=> // [RULE3]
                                           aux_dac_level_r == code_r && aux_adc_result_r == $past(adc_result_in))
        else $error("DAC level does not carry the state code");
    AST_RELEASE: assert property ($fell(monitor_en) |-> aux_adc_result_r == code_r || // [RULE16]
                                  aux_dac_level_r == code_r ##1 aux_adc_result_r == $past(adc_result_in))
        else $error("converter path not returned after observation ends");
    AST_WAIT_CODE: assert property (state_r == ST_WAIT |-> code_r == CODE_WAIT && !preamble_det_r) // [RULE5]
        else $error("waiting state shows wrong code");
    AST_BURST_START: assert property (state_r == ST_WAIT && rx_active && mag_r > detect_thr |=> // [RULE14]
                                      state_r == ST_BURST && preamble_det_r && code_r == CODE_BURST)
        else $error("burst start not taken on detect crossing");
    AST_NOHI_CODE: assert property (state_r == ST_PRE_NOHI && state_nxt == ST_PRE_NOHI && // [RULE7]
                                    !clip_r && rx_active |=> !gain_dn_r && code_r == CODE_PRE_NOHI)
        else $error("high threshold acted in preamble no-high state");
    AST_LOCK_HOLD: assert property (state_r == ST_FS_LOCK && state_nxt == ST_FS_LOCK && // [RULE8]
                                    agc_mode != MODE_MANUAL |=> $stable(gain_step_r) && code_r == CODE_FS_LOCK)
        else $error("gain moved after frame sync lock");
    AST_DOWN_ONLY: assert property (state_r == ST_FS_DOWN && state_nxt == ST_FS_DOWN |=> // [RULE9]
                                    !gain_up_r && code_r == CODE_FS_DOWN)
        else $error("gain rose in reduction-only state");
    AST_ANY_NO_UPDATE: assert property (state_r == ST_FS_ANY && state_nxt == ST_FS_ANY |=> // [RULE10]
                                        $stable(code_r))
        else $error("code changed in any-action state");
    AST_MANUAL: assert property (agc_mode == MODE_MANUAL |=> gain_step_r == $past(manual_step)) // [RULE13]
        else $error("manual step not applied");

    COV_BURST_TO_LOCK: cover property (state_r == ST_BURST ##[1:1000] state_r == ST_FS_LOCK);
    COV_NOHI_ENTRY: cover property (state_r == ST_BURST ##1 state_r == ST_PRE_NOHI);
    COV_GAIN_DOWN: cover property (gain_dn_r && monitor_en);
    COV_GAIN_UP: cover property (gain_up_r);

endmodule

// ---- hdl/gso_pkg.sv ----
// Constants, codes and types shared by the gain state observer
package gso_pkg;

    localparam int          CODE_W        = 10;
    localparam int          STEP_W        = 3;
    localparam int          MAG_W         = 16;
    localparam int          TIME_W        = 8;

    // Observation codes written in place of a converter value
    localparam logic [9:0]  CODE_WAIT     = 10'h000;
    localparam logic [9:0]  CODE_BURST    = 10'h100;
    localparam logic [9:0]  CODE_PRE_NOHI = 10'h200;
    localparam logic [9:0]  CODE_FS_LOCK  = 10'h300;
    localparam logic [9:0]  CODE_FS_DOWN  = 10'h380;

    // Gain steps: 0 is the lowest gain, 7 the highest
    localparam int          GAIN_STEPS    = 8;
    localparam logic [2:0]  STEP_TOP      = 3'h7;
    localparam logic [2:0]  STEP_ONE      = 3'h1;

    // Bit positions of the permitted action mask
    localparam int          ACT_CLIP      = 0;
    localparam int          ACT_HI        = 1;
    localparam int          ACT_LO        = 2;

    // Routing of the observation code
    localparam logic        SEL_ADC       = 1'b0;
    localparam logic        SEL_DAC       = 1'b1;

    // Timing unit is 6/5 of a symbol period
    localparam longint      CLK_HZ        = 40000000;
    localparam longint      SYMBOL_HZ     = 9600;
    localparam longint      UNIT_NUM      = 6;
    localparam longint      UNIT_DEN      = 5;
    localparam int          UNIT_CYCLES   = int'((CLK_HZ * UNIT_NUM) / (SYMBOL_HZ * UNIT_DEN));

    typedef enum logic [2:0] {
        ST_WAIT     = 3'b000,
        ST_BURST    = 3'b001,
        ST_PRE_NOHI = 3'b010,
        ST_FS_LOCK  = 3'b011,
        ST_FS_DOWN  = 3'b100,
        ST_FS_ANY   = 3'b101
    } gso_state_e;

    typedef enum logic [1:0] {
        MODE_MANUAL = 2'b00,
        MODE_FULL   = 2'b01,
        MODE_LOCK   = 2'b10,
        MODE_DOWN   = 2'b11
    } gso_mode_e;

endpackage

// ---- hdl/gso_unit_tick.sv ----
// Timing unit tick generator, one pulse per unit of 6/5 symbol period
module gso_unit_tick
    import gso_pkg::*;
#(
    parameter int UNIT_CYCLES = gso_pkg::UNIT_CYCLES
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic clear,
    output logic      tick_r
);
    localparam int          CNT_W   = (UNIT_CYCLES > 1) ? $clog2(UNIT_CYCLES) : 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(UNIT_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             tick_nxt;

    // Clearing restarts the unit so timers begin on a whole unit
    always_comb begin
        cnt_nxt  = cnt_r + CNT_W'(1);
        tick_nxt = 1'b0;
        if (clear) begin
            cnt_nxt = CNT_ZERO;
        end else if (cnt_r == CNT_LAST) begin
            cnt_nxt  = CNT_ZERO;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

endmodule
